// ===== hw/rise_status_pkg.sv
// Purpose: Shared constants for the paged rise-time and status register bank.
// Assumes: Command codes are byte-wide; data words are 16 bits.
// Notes: Rise-time word is linear with a fixed exponent of -4.
package rise_status_pkg;
	// Command codes of the bank.
	localparam logic [7:0] CMD_RISE_TIME = 8'h61;
	localparam logic [7:0] CMD_FAULT_BYTE = 8'h78;
	localparam logic [7:0] CMD_FAULT_WORD = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLAG_STATUS = 8'h7a;
	// Rise-time word layout and reset value.
	localparam logic [4:0] RISE_EXPONENT = 5'h1c;
	localparam logic [7:0] RISE_MANT_RESET = 8'h2b;
	localparam int RISE_EXP_LSB = 11;
	// Supported steps in microseconds: 0.6 ms is 9.6 in 1/16 ms units, so compare in us.
	localparam int RISE_STEPS = 8;
	localparam int STEP_US [RISE_STEPS] = '{600, 900, 1200, 1800, 2700, 4200, 6000, 9000};
	localparam int RESET_STEP = 4;
	// Clock rate and derived cycles per microsecond.
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
	// Fault summary byte bit positions.
	localparam int SB_OFF = 6;
	localparam int SB_OUTPUT_OVERVOLTAGE_FLAG = 5;
	localparam int SB_OUTPUT_OVERCURRENT_FLAG = 4;
	localparam int SB_INPUT_UNDERVOLTAGE_FLAG = 3;
	localparam int SB_TEMP = 2;
	localparam int SB_CML = 1;
	localparam int SB_OTHER = 0;
	// Status word high byte bit positions.
	localparam int SW_OUTPUT_VOLTAGE_FLAG = 7;
	localparam int SW_IOUT = 6;
	localparam int SW_MFR = 4;
	localparam int SW_PGOOD = 3;
	// Output voltage status bit positions.
	localparam int SV_OV = 7;
	localparam int SV_UV = 4;
	// Communication status invalid-data bit.
	localparam int CS_INVALID_DATA = 6;
	localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

// ===== hw/rise_status_bank.sv
// Purpose: Paged rise-time setting and fault status register bank with ramp timing.
// Assumes: Command decoding and byte assembly happen upstream; a write is one strobe.
// Notes: Fault inputs are levels from the analog detectors, already on core_clk_in.
`timescale 1ns/100ps
module rise_status_bank #(
	parameter int PAGES = 2
) (
	// Clock and reset.
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	// Command port from the management-bus engine.
	input wire logic [$clog2(PAGES)-1:0] page_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic wr_stb_in,
	input wire logic [15:0] wr_data_in,
	input wire logic clear_faults_in,
	input wire logic store_all_in,
	output logic [15:0] rd_data_out,
	// Non-volatile store request, one pulse per page value.
	output logic nvm_store_out,
	output logic [$clog2(PAGES)-1:0] nvm_page_out,
	output logic [7:0] nvm_data_out,
	// Detector levels per page; two-phase and the communication fault inputs are shared.
	input wire logic [PAGES-1:0] power_on_in,
	input wire logic [PAGES-1:0] output_overvoltage_flag_fault_in,
	input wire logic [PAGES-1:0] output_voltage_flag_uv_fault_in,
	input wire logic [PAGES-1:0] output_voltage_flag_warn_in,
	input wire logic [PAGES-1:0] output_overcurrent_flag_fault_in,
	input wire logic [PAGES-1:0] output_overcurrent_flag_warn_in,
	input wire logic [PAGES-1:0] input_undervoltage_flag_fault_in,
	input wire logic [PAGES-1:0] temp_fault_in,
	input wire logic [PAGES-1:0] temp_warn_in,
	input wire logic [PAGES-1:0] thermal_shutdown_in,
	input wire logic [PAGES-1:0] power_good_fail_in,
	input wire logic two_phase_in,
	input wire logic comm_fault_in,
	input wire logic other_comm_fault_in,
	// Ramp control per page.
	input wire logic [PAGES-1:0] ramp_start_in,
	input wire logic [PAGES-1:0] ref_step_in,
	output logic [PAGES-1:0] ramp_tick_out,
	output logic [PAGES-1:0] ramp_done_out,
	// Alert and communication status.
	output logic alert_n_out,
	output logic [7:0] communication_status_out
);
	localparam int PW = $clog2(PAGES);

	// Rise-time mantissa, status copies, ramp counters, per page.
	logic [7:0] rise_mant_ff [PAGES];
	logic [2:0] rise_step_ff [PAGES];
	logic [7:0] fault_byte_ff [PAGES];
	logic [7:0] word_high_ff [PAGES];
	logic [7:0] output_voltage_flag_status_ff [PAGES];
	logic [23:0] ramp_cnt_ff [PAGES];
	logic [PAGES-1:0] ramping_ff;
	logic [7:0] comm_status_ff;
	logic cml_pending;
	logic invalid_wr;
	logic [2:0] nxt_step;
	logic [PW:0] store_idx_ff;
	logic storing_ff;
	logic alert_any;

	// Snap a written time (mantissa/16 ms) to the nearest supported step.
	function automatic logic [2:0] nearest_step(input logic [7:0] mant);
		int us;
		int best;
		int bd;
		int d;
		us = (int'(mant) * 1000) / 16;
		best = 0;
		bd = 100000;
		for (int i = 0; i < rise_status_pkg::RISE_STEPS; i++) begin
			d = us - rise_status_pkg::STEP_US[i];
			if (d < 0) begin
				d = -d;
			end
			if (d < bd) begin
				bd = d;
				best = i;
			end
		end
		return best[2:0];
	endfunction

	// Writes to status commands, or rise-time writes with an exponent other than -4 or nonzero bits 10:8, are invalid.
	always_comb begin
		invalid_wr = 1'b0;
		if (wr_stb_in) begin
			if (cmd_code_in == rise_status_pkg::CMD_FAULT_BYTE
					|| cmd_code_in == rise_status_pkg::CMD_FAULT_WORD
					|| cmd_code_in == rise_status_pkg::CMD_OUTPUT_VOLTAGE_FLAG_STATUS) begin
				invalid_wr = 1'b1;
			end else if (cmd_code_in == rise_status_pkg::CMD_RISE_TIME
					&& (wr_data_in[15:rise_status_pkg::RISE_EXP_LSB] != rise_status_pkg::RISE_EXPONENT
					|| wr_data_in[10:8] != 3'h0)) begin
				invalid_wr = 1'b1;
			end
		end
	end
	assign cml_pending = invalid_wr | comm_fault_in;
	assign nxt_step = nearest_step(wr_data_in[7:0]);

	// Communication status: invalid data sticks until faults are cleared; set wins.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			comm_status_ff <= rise_status_pkg::STATUS_RESET;
		end else if (invalid_wr) begin
			comm_status_ff[rise_status_pkg::CS_INVALID_DATA] <= 1'b1;
		end else if (clear_faults_in) begin
			comm_status_ff <= rise_status_pkg::STATUS_RESET;
		end
	end

	// Per-page registers, status latching and ramp timer.
	genvar g;
	generate
		for (g = 0; g < PAGES; g++) begin : page_g
			logic sel;
			logic [7:0] fb_set;
			logic [7:0] wh_set;
			logic [7:0] vs_set;
			logic [23:0] ramp_len;
			assign sel = (page_in == PW'(g));
			// Events that set each status byte this cycle.
			always_comb begin
				fb_set = 8'h00;
				fb_set[rise_status_pkg::SB_OFF] = ~power_on_in[g];
				fb_set[rise_status_pkg::SB_OUTPUT_OVERVOLTAGE_FLAG] = output_overvoltage_flag_fault_in[g];
				fb_set[rise_status_pkg::SB_OUTPUT_OVERCURRENT_FLAG] = output_overcurrent_flag_fault_in[g];
				fb_set[rise_status_pkg::SB_INPUT_UNDERVOLTAGE_FLAG] = input_undervoltage_flag_fault_in[g];
				fb_set[rise_status_pkg::SB_TEMP] = temp_fault_in[g] | temp_warn_in[g];
				fb_set[rise_status_pkg::SB_CML] = cml_pending & (sel | comm_fault_in);
				fb_set[rise_status_pkg::SB_OTHER] = output_voltage_flag_uv_fault_in[g] | output_overcurrent_flag_warn_in[g]
					| output_voltage_flag_warn_in[g] | thermal_shutdown_in[g] | other_comm_fault_in;
				wh_set = 8'h00;
				wh_set[rise_status_pkg::SW_OUTPUT_VOLTAGE_FLAG] = output_overvoltage_flag_fault_in[g] | output_voltage_flag_uv_fault_in[g]
					| output_voltage_flag_warn_in[g];
				wh_set[rise_status_pkg::SW_IOUT] = output_overcurrent_flag_fault_in[g] | output_overcurrent_flag_warn_in[g];
				wh_set[rise_status_pkg::SW_MFR] = thermal_shutdown_in[g];
				wh_set[rise_status_pkg::SW_PGOOD] = power_good_fail_in[g] & ~two_phase_in;
				vs_set = 8'h00;
				vs_set[rise_status_pkg::SV_OV] = output_overvoltage_flag_fault_in[g];
				vs_set[rise_status_pkg::SV_UV] = output_voltage_flag_uv_fault_in[g];
			end
			// Sticky flags; a set in the clearing cycle survives.
			always_ff @(posedge core_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					fault_byte_ff[g] <= rise_status_pkg::STATUS_RESET;
					word_high_ff[g] <= rise_status_pkg::STATUS_RESET;
					output_voltage_flag_status_ff[g] <= rise_status_pkg::STATUS_RESET;
				end else if (clear_faults_in) begin
					fault_byte_ff[g] <= fb_set;
					word_high_ff[g] <= wh_set;
					output_voltage_flag_status_ff[g] <= vs_set;
				end else begin
					fault_byte_ff[g] <= fault_byte_ff[g] | fb_set;
					word_high_ff[g] <= word_high_ff[g] | wh_set;
					output_voltage_flag_status_ff[g] <= output_voltage_flag_status_ff[g] | vs_set;
				end
			end
			// Rise-time mantissa and snapped step.
			always_ff @(posedge core_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					rise_mant_ff[g] <= rise_status_pkg::RISE_MANT_RESET;
					rise_step_ff[g] <= 3'(rise_status_pkg::RESET_STEP);
				end else if (sel && wr_stb_in && !invalid_wr
						&& cmd_code_in == rise_status_pkg::CMD_RISE_TIME) begin
					rise_mant_ff[g] <= wr_data_in[7:0];
					rise_step_ff[g] <= nxt_step;
				end
			end
			// Ramp length in cycles; zero mantissa means immediate.
			assign ramp_len = (rise_mant_ff[g] == 8'h00) ? 24'h000000 :
				24'(rise_status_pkg::STEP_US[rise_step_ff[g]] * rise_status_pkg::CYC_PER_US);
			// Ramp timer restarts on ramp start or a reference step in soft-start.
			always_ff @(posedge core_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					ramp_cnt_ff[g] <= 24'h000000;
					ramping_ff[g] <= 1'b0;
				end else if (ramp_start_in[g] || (ref_step_in[g] && ramping_ff[g])) begin
					ramp_cnt_ff[g] <= ramp_len;
					ramping_ff[g] <= (ramp_len != 24'h000000);
				end else if (ramping_ff[g]) begin
					ramp_cnt_ff[g] <= ramp_cnt_ff[g] - 24'h000001;
					ramping_ff[g] <= (ramp_cnt_ff[g] > 24'h000001);
				end
			end
			assign ramp_tick_out[g] = ramping_ff[g];
			assign ramp_done_out[g] = ~ramping_ff[g];
		end
	endgenerate

	// Read mux for the selected page.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_out <= 16'h0000;
		end else begin
			case (cmd_code_in)
				rise_status_pkg::CMD_RISE_TIME: rd_data_out <= {rise_status_pkg::RISE_EXPONENT,
					3'h0, rise_mant_ff[page_in]};
				rise_status_pkg::CMD_FAULT_BYTE: rd_data_out <= {8'h00, fault_byte_ff[page_in]};
				rise_status_pkg::CMD_FAULT_WORD: rd_data_out <= {word_high_ff[page_in],
					fault_byte_ff[page_in]};
				rise_status_pkg::CMD_OUTPUT_VOLTAGE_FLAG_STATUS: rd_data_out <= {8'h00, output_voltage_flag_status_ff[page_in]};
				default: rd_data_out <= 16'h0000;
			endcase
		end
	end

	// Store sequencer walks every page, one pulse each.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			storing_ff <= 1'b0;
			store_idx_ff <= '0;
			nvm_store_out <= 1'b0;
			nvm_page_out <= '0;
			nvm_data_out <= 8'h00;
		end else begin
			nvm_store_out <= 1'b0;
			if (store_all_in && !storing_ff) begin
				storing_ff <= 1'b1;
				store_idx_ff <= '0;
			end else if (storing_ff) begin
				nvm_store_out <= 1'b1;
				nvm_page_out <= store_idx_ff[PW-1:0];
				nvm_data_out <= rise_mant_ff[store_idx_ff[PW-1:0]];
				store_idx_ff <= store_idx_ff + 1'b1;
				storing_ff <= (store_idx_ff != (PW+1)'(PAGES - 1));
			end
		end
	end

	// Any reportable flag on any page, except the plain off state.
	always_comb begin
		alert_any = 1'b0;
		for (int i = 0; i < PAGES; i++) begin
			alert_any = alert_any | (|fault_byte_ff[i][5:0]) | (|word_high_ff[i]);
		end
	end

	// Alert is low while a reportable flag or invalid data is held.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			alert_n_out <= 1'b1;
		end else begin
			alert_n_out <= ~(alert_any | comm_status_ff[rise_status_pkg::CS_INVALID_DATA]);
		end
	end
	assign communication_status_out = comm_status_ff;
endmodule

// ===== bench/rise_status_chk.sv
// Purpose: Port assertions for the paged rise-time and status bank.
// Assumes: Two pages; a read answers one edge after the command code.
// Notes: Bound to every instance of the bank.
`timescale 1ns/100ps
module rise_status_chk #(
	parameter int PAGES = 2
) (
	// Clock, reset and commands.
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic wr_stb_in,
	input wire logic clear_faults_in,
	input wire logic store_all_in,
	input wire logic [PAGES-1:0] output_overvoltage_flag_fault_in,
	input wire logic [PAGES-1:0] ramp_start_in,
	input wire logic [PAGES-1:0] ref_step_in,
	// Watched outputs.
	input wire logic [15:0] rd_data_out,
	input wire logic nvm_store_out,
	input wire logic [PAGES-1:0] ramp_tick_out,
	input wire logic [PAGES-1:0] ramp_done_out,
	input wire logic alert_n_out,
	input wire logic [7:0] communication_status_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// Each label except chk_done_inverse and chk_flag_sticky ties an output to the command or event that caused it.
	chk_done_inverse: assert property (ramp_done_out == ~ramp_tick_out)
		else $error("ramp done is not the inverse of ramp tick");
	chk_ramp_cause: assert property ($rose(ramp_tick_out[0]) |-> $past(ramp_start_in[0] | ref_step_in[0]))
		else $error("ramp started without a request");
	chk_status_ro: assert property (wr_stb_in && cmd_code_in == 8'h78 |-> ##[1:2] communication_status_out[6])
		else $error("status write was not refused");
	chk_refuse_alert: assert property (wr_stb_in && cmd_code_in == 8'h7a |-> ##[1:3] !alert_n_out)
		else $error("refused write did not raise alert");
	chk_alert_fault: assert property (output_overvoltage_flag_fault_in[0] |-> ##[1:3] !alert_n_out)
		else $error("fault did not raise alert");
	chk_store_pages: assert property (store_all_in |=> ##1 nvm_store_out [*2] ##1 !nvm_store_out)
		else $error("store did not pulse once per page");
	chk_flag_sticky: assert property (communication_status_out[6] && !clear_faults_in |=> communication_status_out[6])
		else $error("invalid data flag dropped without clear");
	chk_byte_upper: assert property (cmd_code_in == 8'h78 |=> rd_data_out[15:7] == 9'h000)
		else $error("fault byte read has upper bits set");
	chk_output_voltage_flag_unused: assert property (cmd_code_in == 8'h7a |=> (rd_data_out & 16'hff6f) == 16'h0000)
		else $error("voltage status unused bits set");
	chk_rise_upper: assert property (cmd_code_in == 8'h61 |=> rd_data_out[15:10] == 6'h38)
		else $error("rise time exponent or fixed bits wrong");
	// Main scenarios reached.
	cov_store: cover property (store_all_in ##2 nvm_store_out);
	cov_refused: cover property (wr_stb_in && cmd_code_in == 8'h78);
	cov_ramp: cover property ($rose(ramp_tick_out[0]));
endmodule
bind rise_status_bank rise_status_chk #(.PAGES(PAGES)) chk_u (.core_clk_in(core_clk_in),
	.arst_n_in(arst_n_in), .cmd_code_in(cmd_code_in), .wr_stb_in(wr_stb_in),
	.clear_faults_in(clear_faults_in), .store_all_in(store_all_in),
	.output_overvoltage_flag_fault_in(output_overvoltage_flag_fault_in), .ramp_start_in(ramp_start_in),
	.ref_step_in(ref_step_in), .rd_data_out(rd_data_out), .nvm_store_out(nvm_store_out),
	.ramp_tick_out(ramp_tick_out), .ramp_done_out(ramp_done_out), .alert_n_out(alert_n_out),
	.communication_status_out(communication_status_out));

// ===== bench/mgmt_host.sv
// Purpose: Management-bus host model issuing commands to the bank.
// Assumes: One command at a time, launched just after a rising edge.
// Notes: Read data is taken two edges after the command is set up.
`timescale 1ns/100ps
module mgmt_host (
	// Clock and read data.
	input wire logic core_clk_in,
	input wire logic [15:0] rd_data_in,
	// Command lines.
	output logic [0:0] page_out = 1'b0,
	output logic [7:0] cmd_out = 8'h00,
	output logic wr_stb_out = 1'b0,
	output logic [15:0] wr_data_out = 16'h0000,
	output logic clear_out = 1'b0,
	output logic store_out = 1'b0
);
	// Write one word; the strobe stands for one edge only.
	task automatic wr(input logic [0:0] p, input logic [7:0] c, input logic [15:0] d);
		@(posedge core_clk_in);
		page_out <= p;
		cmd_out <= c;
		wr_data_out <= d;
		wr_stb_out <= 1'b1;
		@(posedge core_clk_in);
		wr_stb_out <= 1'b0;
	endtask
	// Read holds page and code until the registered answer has settled.
	task automatic rd(input logic [0:0] p, input logic [7:0] c, output logic [15:0] v);
		@(posedge core_clk_in);
		page_out <= p;
		cmd_out <= c;
		repeat (2) @(posedge core_clk_in);
		#1;
		v = rd_data_in;
	endtask
	// One-edge pulse of clear (0) or store-all (1).
	task automatic pulse(input logic st);
		@(posedge core_clk_in);
		if (st) store_out <= 1'b1;
		else clear_out <= 1'b1;
		@(posedge core_clk_in);
		store_out <= 1'b0;
		clear_out <= 1'b0;
	endtask
endmodule

// ===== bench/rise_status_bank_bench.sv
// Purpose: Self-checking bench for the rise-time and status bank.
// Assumes: Two pages; ramp lengths counted at the full documented scale.
// Notes: Detector levels are pulsed on page 0 unless noted.
`timescale 1ns/100ps
module rise_status_bank_bench;
	logic core_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [0:0] pg, nvm_pg;
	logic [7:0] cmd, nvm_d, cs;
	logic stb, clr, sto, alert_n, nvm_st;
	logic [15:0] wd, rdd, v;
	logic [1:0] det [10] = '{default: 2'b00};
	logic [1:0] pwr = 2'b11, start = 2'b00, cf = 2'b00, ref_step = 2'b00, tick, done;
	logic two_phase = 1'b0;
	logic [15:0] fexp [10] = '{16'h8020, 16'h8001, 16'h8001, 16'h4010, 16'h4001, 16'h0008,
		16'h0004, 16'h0004, 16'h1001, 16'h0800};
	int n_mismatch = 0, samples_checked = 0, cyc = 0, n;
	always #5 core_clk_in = ~core_clk_in;
	mgmt_host host_u (.core_clk_in(core_clk_in), .rd_data_in(rdd), .page_out(pg), .cmd_out(cmd),
		.wr_stb_out(stb), .wr_data_out(wd), .clear_out(clr), .store_out(sto));
	rise_status_bank dut_u (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .page_in(pg),
		.cmd_code_in(cmd), .wr_stb_in(stb), .wr_data_in(wd), .clear_faults_in(clr),
		.store_all_in(sto), .rd_data_out(rdd), .nvm_store_out(nvm_st), .nvm_page_out(nvm_pg),
		.nvm_data_out(nvm_d), .power_on_in(pwr), .output_overvoltage_flag_fault_in(det[0]),
		.output_voltage_flag_uv_fault_in(det[1]), .output_voltage_flag_warn_in(det[2]), .output_overcurrent_flag_fault_in(det[3]),
		.output_overcurrent_flag_warn_in(det[4]), .input_undervoltage_flag_fault_in(det[5]), .temp_fault_in(det[6]),
		.temp_warn_in(det[7]), .thermal_shutdown_in(det[8]), .power_good_fail_in(det[9]),
		.two_phase_in(two_phase), .comm_fault_in(cf[0]), .other_comm_fault_in(cf[1]),
		.ramp_start_in(start), .ref_step_in(ref_step), .ramp_tick_out(tick), .ramp_done_out(done),
		.alert_n_out(alert_n), .communication_status_out(cs));
	// Compare one value and count it.
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Read a register and compare it.
	task automatic rdc(input logic [0:0] p, input logic [7:0] c, input logic [15:0] e);
		host_u.rd(p, c, v);
		check($sformatf("cmd %h page %0d", c, p), v, e);
	endtask
	// Hold a level for one edge on page 0 or 1, then release it.
	task automatic hit(input int i, input int p);
		@(posedge core_clk_in);
		det[i][p] <= 1'b1;
		@(posedge core_clk_in);
		det[i][p] <= 1'b0;
	endtask
	// Single place where the run ends.
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Cycle ceiling guards against a hang.
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_mismatch++;
			conclude();
		end
	end
	// Main sequence.
	initial begin
		repeat (3) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		rdc(0, 8'h61, 16'he02b);
		rdc(1, 8'h61, 16'he02b);
		rdc(0, 8'h79, 16'h0000);
		rdc(1, 8'h7a, 16'h0000);
		host_u.wr(1, 8'h61, 16'he00a);
		rdc(1, 8'h61, 16'he00a);
		rdc(0, 8'h61, 16'he02b);
		host_u.wr(0, 8'h78, 16'h0000);
		rdc(0, 8'h78, 16'h0002);
		check("invalid data", {15'h0, cs[6]}, 16'h0001);
		check("alert", {15'h0, alert_n}, 16'h0000);
		host_u.pulse(0);
		host_u.wr(1, 8'h61, 16'h002b);
		rdc(1, 8'h61, 16'he00a);
		rdc(1, 8'h78, 16'h0002);
		host_u.pulse(0);
		for (int i = 0; i < 10; i++) begin
			hit(i, 0);
			rdc(0, 8'h79, fexp[i]);
			check("alert", {15'h0, alert_n}, 16'h0000);
			host_u.pulse(0);
		end
		// In two-phase operation a power-good failure leaves no trace.
		@(posedge core_clk_in);
		two_phase <= 1'b1;
		hit(9, 0);
		rdc(0, 8'h79, 16'h0000);
		@(posedge core_clk_in);
		two_phase <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			hit(i, 1);
			rdc(1, 8'h7a, i ? 16'h0010 : 16'h0080);
			host_u.pulse(0);
		end
		@(posedge core_clk_in);
		pwr <= 2'b01;
		rdc(1, 8'h78, 16'h0040);
		@(posedge core_clk_in);
		pwr <= 2'b11;
		host_u.pulse(0);
		host_u.wr(0, 8'h7a, 16'h0000);
		rdc(0, 8'h78, 16'h0002);
		check("alert", {15'h0, alert_n}, 16'h0000);
		host_u.pulse(0);
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk_in);
			cf[i] <= 1'b1;
			@(posedge core_clk_in);
			cf[i] <= 1'b0;
			rdc(1, 8'h78, i ? 16'h0001 : 16'h0002);
			host_u.pulse(0);
		end
		host_u.pulse(1);
		@(posedge core_clk_in);
		#1;
		check("store page 0", {nvm_st, 6'h00, nvm_pg, nvm_d}, 16'h802b);
		@(posedge core_clk_in);
		#1;
		check("store page 1", {nvm_st, 6'h00, nvm_pg, nvm_d}, 16'h810a);
		// A mantissa of 10 is 0.625 ms and snaps to the 600 us step.
		// A reference step after 100 cycles of soft-start restarts the full ramp.
		host_u.wr(0, 8'h61, 16'he00a);
		@(posedge core_clk_in);
		start <= 2'b01;
		@(posedge core_clk_in);
		start <= 2'b00;
		#1;
		n = 0;
		while (tick[0] === 1'b1 && n < 70000) begin
			n++;
			@(posedge core_clk_in);
			ref_step <= {1'b0, n == 100};
			#1;
		end
		check("ramp cycles", n[15:0], 16'heac5);
		check("ramp done", {15'h0, done[0]}, 16'h0001);
		host_u.wr(0, 8'h61, 16'he000);
		@(posedge core_clk_in);
		start <= 2'b01;
		@(posedge core_clk_in);
		start <= 2'b00;
		n = 0;
		repeat (20) begin
			@(posedge core_clk_in);
			if (tick[0] !== 1'b0) n++;
		end
		check("fast ramp ticks", n[15:0], 16'h0000);
		conclude();
	end
endmodule
